// >>> verilog/sdac_defines.vh
`ifndef SDAC_DEFINES_VH
`define SDAC_DEFINES_VH
// Register byte offsets.
`define SDAC_CSC_ADDR 12'h000
`define SDAC_FW_ADDR 12'h004
`define SDAC_MODE_ADDR 12'h008
`define SDAC_STAT_ADDR 12'h00c
`define SDAC_PCC_ADDR 12'h010
`define SDAC_ACC_ADDR 12'h014
`define SDAC_PDATA_ADDR 12'h018
`define SDAC_ADATA_ADDR 12'h01c
`define SDAC_POFF_ADDR 12'h020
`define SDAC_PGAIN_ADDR 12'h024
`define SDAC_AOFF_ADDR 12'h028
`define SDAC_AGAIN_ADDR 12'h02c
// Field positions.
`define SDAC_CSC_BURNOUT 0
`define SDAC_MODE_PEN 4
`define SDAC_MODE_AEN 5
`define SDAC_STAT_PRDY 7
`define SDAC_STAT_ARDY 6
`define SDAC_STAT_BUSY 5
`define SDAC_STAT_NOREF 4
`define SDAC_STAT_PERR 3
`define SDAC_STAT_AERR 2
// Excitation routing codes.
`define SDAC_ROUTE_A 2'h1
`define SDAC_ROUTE_B 2'h2
// Converter modes.
`define SDAC_MODE_IDLE 3'h0
`define SDAC_MODE_SINGLE 3'h1
`define SDAC_MODE_CONT 3'h2
`define SDAC_MODE_IZS 3'h4
`define SDAC_MODE_IFS 3'h5
`define SDAC_MODE_SZS 3'h6
`define SDAC_MODE_SFS 3'h7
// Modulator input selection codes.
`define SDAC_SEL_PINS 2'h0
`define SDAC_SEL_ZERO 2'h1
`define SDAC_SEL_FULL 2'h2
// Reset values and filter timing.
`define SDAC_CSC_RESET 5'h00
`define SDAC_FW_RESET 8'h45
`define SDAC_FW_SLOWEST 8'hff
`define SDAC_MODE_RESET 6'h00
`endif

// >>> verilog/sdac_sinc3.v
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Third-order cascaded integrator comb decimator for one modulator stream.
module sdac_sinc3 #(
  parameter RW = 11,
  parameter ACC = 34
) (
  input wire pclk,
  input wire presetn,
  input wire restart,
  input wire sample_valid,
  input wire sample_bit,
  input wire [RW-1:0] decim,
  output reg out_valid,
  output reg [ACC-1:0] out_word
);

  reg [ACC-1:0] int1;
  reg [ACC-1:0] int2;
  reg [ACC-1:0] int3;
  reg [ACC-1:0] dly1;
  reg [ACC-1:0] dly2;
  reg [ACC-1:0] dly3;
  reg [RW-1:0] count;

  // Comb differences at the decimated rate; wraparound is harmless.
  wire [ACC-1:0] diff1 = int3 - dly1;
  wire [ACC-1:0] diff2 = diff1 - dly2;
  wire [ACC-1:0] diff3 = diff2 - dly3;
  wire dump = (count == decim - 1'b1);

  ////////////////////////////////////////////////////////////////////////////////
  // Integrators run per sample, combs once per decimation period.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int1 <= {ACC{1'b0}};
      int2 <= {ACC{1'b0}};
      int3 <= {ACC{1'b0}};
      dly1 <= {ACC{1'b0}};
      dly2 <= {ACC{1'b0}};
      dly3 <= {ACC{1'b0}};
      count <= {RW{1'b0}};
      out_valid <= 1'b0;
      out_word <= {ACC{1'b0}};
    end else begin
      out_valid <= 1'b0;
      if (restart) begin
        int1 <= {ACC{1'b0}};
        int2 <= {ACC{1'b0}};
        int3 <= {ACC{1'b0}};
        dly1 <= {ACC{1'b0}};
        dly2 <= {ACC{1'b0}};
        dly3 <= {ACC{1'b0}};
        count <= {RW{1'b0}};
      end else if (sample_valid) begin
        int1 <= int1 + {{(ACC-1){1'b0}}, sample_bit};
        int2 <= int2 + int1;
        int3 <= int3 + int2;
        if (dump) begin
          count <= {RW{1'b0}};
          dly1 <= int3;
          dly2 <= diff1;
          dly3 <= diff2;
          out_word <= diff3;
          out_valid <= 1'b1;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end

endmodule // sdac_sinc3

`default_nettype wire

// >>> verilog/sdac_control.v
// Local design decisions: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "sdac_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// Control, calibration and post-processing for two sigma-delta channels.
module sdac_control #(
  parameter DW = 24,
  parameter FW = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  input wire mod_sample_valid,
  input wire mod_bit_primary,
  input wire mod_bit_aux,
  input wire ref_below_threshold,
  input wire ref_pos_open,
  input wire ref_neg_open,
  input wire [DW-1:0] factory_offset_primary,
  input wire [DW-1:0] factory_gain_primary,
  input wire [DW-1:0] factory_offset_aux,
  input wire [DW-1:0] factory_gain_aux,
  output wire burnout_source_en,
  output wire burnout_sink_en,
  output wire [1:0] excitation_out_a,
  output wire [1:0] excitation_out_b,
  output wire [1:0] primary_input_select,
  output wire [1:0] aux_input_select,
  output reg chop_swap
);

  localparam RW = FW + 3;
  localparam ACC = 3 * RW + 1;
  localparam [DW-1:0] ALL_ONES = {DW{1'b1}};

  reg [4:0] current_source_control;
  reg [FW-1:0] filter_word;
  reg [5:0] converter_mode_control;
  reg primary_converter_control;
  reg aux_converter_control;
  reg [1:0] conversion_ready_flags;
  reg primary_cal_error;
  reg aux_cal_error;
  reg reference_missing_flag;
  reg [DW-1:0] data_out [0:1];
  reg [DW-1:0] offset_coef [0:1];
  reg [DW-1:0] gain_coef [0:1];
  reg [DW-1:0] prev_word [0:1];
  reg [1:0] chop_primed;
  reg [1:0] cal_pending;
  reg [1:0] cal_ref_bad;
  reg factory_load;
  reg [31:0] next_rdata;
  reg next_err;
  integer c;

  ////////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Counts how many excitation sources are routed to one pin.
  function [1:0] pin_load;
    input [1:0] route1;
    input [1:0] route2;
    input [1:0] pin;
    begin
      pin_load = {1'b0, route1 == pin} + {1'b0, route2 == pin};
    end
  endfunction

  // Removes offset, scales by the 1.(DW-1) gain, then codes the output.
  function [DW-1:0] post_process;
    input [DW-1:0] raw;
    input [DW-1:0] off;
    input [DW-1:0] gain;
    input uni;
    reg signed [DW+1:0] diff;
    reg signed [2*DW+2:0] prod;
    reg signed [DW+2:0] v;
    begin
      diff = $signed({2'b00, raw}) - $signed({2'b00, off});
      prod = diff * $signed({1'b0, gain});
      v = $signed(prod[2*DW+1:DW-1]);
      if (!uni) begin
        v = v + $signed({3'b000, 1'b1, {(DW-1){1'b0}}});
      end
      if (v < 0) begin
        post_process = {DW{1'b0}};
      end else if (v > $signed({3'b000, ALL_ONES})) begin
        post_process = ALL_ONES;
      end else begin
        post_process = v[DW-1:0];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Decoded control state.

  wire [2:0] mode = converter_mode_control[2:0];
  wire [1:0] chan_en = {converter_mode_control[`SDAC_MODE_AEN],
                        converter_mode_control[`SDAC_MODE_PEN]};
  wire cal_mode = mode[2];
  wire normal_mode = (mode == `SDAC_MODE_CONT) || (mode == `SDAC_MODE_SINGLE);
  wire [1:0] unipolar = {aux_converter_control, primary_converter_control};
  wire cal_done = cal_mode && (cal_pending == 2'b00);

  // APB phases; the slave never inserts wait states.
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire rd = access && !pwrite;
  assign pready = 1'b1;

  wire wr_mode = wr && (paddr == `SDAC_MODE_ADDR);
  wire wr_fw = wr && (paddr == `SDAC_FW_ADDR);
  wire restart = wr_mode || wr_fw || cal_done;

  // Both burnout generators follow the same bit.
  assign burnout_source_en = current_source_control[`SDAC_CSC_BURNOUT];
  assign burnout_sink_en = current_source_control[`SDAC_CSC_BURNOUT];

  // Two sources may go one per pin or both onto one pin.
  assign excitation_out_a = pin_load(current_source_control[2:1],
                                     current_source_control[4:3],
                                     `SDAC_ROUTE_A);
  assign excitation_out_b = pin_load(current_source_control[2:1],
                                     current_source_control[4:3],
                                     `SDAC_ROUTE_B);

  // Internal calibration points are switched in by the device itself.
  wire [1:0] cal_sel = (mode == `SDAC_MODE_IZS) ? `SDAC_SEL_ZERO :
                       (mode == `SDAC_MODE_IFS) ? `SDAC_SEL_FULL :
                       `SDAC_SEL_PINS;
  assign primary_input_select = cal_pending[0] ? cal_sel : `SDAC_SEL_PINS;
  assign aux_input_select = cal_pending[1] ? cal_sel : `SDAC_SEL_PINS;

  // Calibration forces the slowest rate regardless of the filter word.
  wire [FW-1:0] eff_word = cal_mode ? `SDAC_FW_SLOWEST : filter_word;
  wire [RW-1:0] decim = {eff_word, 3'b000};

  ////////////////////////////////////////////////////////////////////////////////
  // Decimators; the chop phase flips the stream so offsets cancel.

  wire [1:0] mod_bits = {mod_bit_aux, mod_bit_primary};
  wire [1:0] f_valid;
  wire [ACC-1:0] f_word [0:1];
  wire [DW-1:0] f_top [0:1];
  wire [DW-1:0] avg [0:1];

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : chan
      wire [DW:0] sum;
      sdac_sinc3 #(
        .RW(RW),
        .ACC(ACC)
      ) u_sinc3 (
        .pclk(pclk),
        .presetn(presetn),
        .restart(restart),
        .sample_valid(mod_sample_valid),
        .sample_bit(mod_bits[g] ^ chop_swap),
        .decim(decim),
        .out_valid(f_valid[g]),
        .out_word(f_word[g])
      );
      assign f_top[g] = f_word[g][ACC-1:ACC-DW];
      // Average of this output and the previous one.
      assign sum = {1'b0, f_top[g]} + {1'b0, prev_word[g]};
      assign avg[g] = sum[DW:1];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Reference detector sample; a plain level, clearing as soon as it is valid.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reference_missing_flag <= 1'b0;
    end else begin
      reference_missing_flag <= ref_below_threshold || ref_pos_open ||
                                ref_neg_open;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Software control registers and hardware mode return.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_source_control <= `SDAC_CSC_RESET;
      filter_word <= `SDAC_FW_RESET;
      converter_mode_control <= `SDAC_MODE_RESET;
      primary_converter_control <= 1'b0;
      aux_converter_control <= 1'b0;
    end else begin
      // Hardware returns to idle after calibration or a single result.
      if (cal_done || (mode == `SDAC_MODE_SINGLE && f_valid[0] && chop_primed[0])) begin
        converter_mode_control[2:0] <= `SDAC_MODE_IDLE;
      end
      if (wr) begin
        if (paddr == `SDAC_CSC_ADDR) begin
          current_source_control <= pwdata[4:0];
        end else if (paddr == `SDAC_FW_ADDR) begin
          filter_word <= pwdata[FW-1:0];
        end else if (paddr == `SDAC_MODE_ADDR) begin
          converter_mode_control <= pwdata[5:0];
        end else if (paddr == `SDAC_PCC_ADDR) begin
          primary_converter_control <= pwdata[0];
        end else if (paddr == `SDAC_ACC_ADDR) begin
          aux_converter_control <= pwdata[0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Chop phase, conversion results, calibration capture and status flags.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chop_swap <= 1'b0;
      chop_primed <= 2'b00;
      cal_pending <= 2'b00;
      cal_ref_bad <= 2'b00;
      conversion_ready_flags <= 2'b00;
      primary_cal_error <= 1'b0;
      aux_cal_error <= 1'b0;
      factory_load <= 1'b1;
      for (c = 0; c < 2; c = c + 1) begin
        data_out[c] <= {DW{1'b0}};
        offset_coef[c] <= {DW{1'b0}};
        gain_coef[c] <= {DW{1'b0}};
        prev_word[c] <= {DW{1'b0}};
      end
    end else begin
      // Factory coefficients are taken once, right after reset release.
      if (factory_load) begin
        factory_load <= 1'b0;
        offset_coef[0] <= factory_offset_primary;
        gain_coef[0] <= factory_gain_primary;
        offset_coef[1] <= factory_offset_aux;
        gain_coef[1] <= factory_gain_aux;
      end
      // Software clears: error bits by writing one, ready by reading data.
      if (wr && paddr == `SDAC_STAT_ADDR) begin
        if (pwdata[`SDAC_STAT_PERR]) begin
          primary_cal_error <= 1'b0;
        end
        if (pwdata[`SDAC_STAT_AERR]) begin
          aux_cal_error <= 1'b0;
        end
      end
      if (rd && paddr == `SDAC_PDATA_ADDR) begin
        conversion_ready_flags[0] <= 1'b0;
      end
      if (rd && paddr == `SDAC_ADATA_ADDR) begin
        conversion_ready_flags[1] <= 1'b0;
      end
      // Software writes to coefficients follow the factory copy.
      if (wr) begin
        if (paddr == `SDAC_POFF_ADDR) begin
          offset_coef[0] <= pwdata[DW-1:0];
        end else if (paddr == `SDAC_PGAIN_ADDR) begin
          gain_coef[0] <= pwdata[DW-1:0];
        end else if (paddr == `SDAC_AOFF_ADDR) begin
          offset_coef[1] <= pwdata[DW-1:0];
        end else if (paddr == `SDAC_AGAIN_ADDR) begin
          gain_coef[1] <= pwdata[DW-1:0];
        end
      end
      if (f_valid[0]) begin
        chop_swap <= ~chop_swap;
      end
      for (c = 0; c < 2; c = c + 1) begin
        if (cal_pending[c] && reference_missing_flag) begin
          cal_ref_bad[c] <= 1'b1;
        end
        if (f_valid[c]) begin
          prev_word[c] <= f_top[c];
          chop_primed[c] <= 1'b1;
          if (chop_primed[c] && cal_pending[c]) begin
            cal_pending[c] <= 1'b0;
            conversion_ready_flags[c] <= 1'b1;
            if (cal_ref_bad[c] || reference_missing_flag) begin
              if (c == 0) begin
                primary_cal_error <= 1'b1;
              end else begin
                aux_cal_error <= 1'b1;
              end
            end else if (!mode[0]) begin
              offset_coef[c] <= avg[c];
            end else begin
              gain_coef[c] <= avg[c];
            end
          end else if (chop_primed[c] && normal_mode && chan_en[c]) begin
            conversion_ready_flags[c] <= 1'b1;
            if (reference_missing_flag) begin
              data_out[c] <= ALL_ONES;
            end else begin
              data_out[c] <= post_process(avg[c], offset_coef[c], gain_coef[c],
                                          unipolar[c]);
            end
          end
        end
      end
      // A new mode write restarts filters and arms enabled calibrations.
      if (restart) begin
        chop_primed <= 2'b00;
        chop_swap <= 1'b0;
      end
      if (wr_mode) begin
        cal_ref_bad <= 2'b00;
        cal_pending <= pwdata[2] ? {pwdata[`SDAC_MODE_AEN],
                                    pwdata[`SDAC_MODE_PEN]} : 2'b00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read decode for the setup phase; unmapped addresses answer with an error.
  always @* begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    if (paddr == `SDAC_CSC_ADDR) begin
      next_rdata[4:0] = current_source_control;
    end else if (paddr == `SDAC_FW_ADDR) begin
      next_rdata[FW-1:0] = filter_word;
    end else if (paddr == `SDAC_MODE_ADDR) begin
      next_rdata[5:0] = converter_mode_control;
    end else if (paddr == `SDAC_STAT_ADDR) begin
      next_rdata[`SDAC_STAT_PRDY] = conversion_ready_flags[0];
      next_rdata[`SDAC_STAT_ARDY] = conversion_ready_flags[1];
      next_rdata[`SDAC_STAT_BUSY] = cal_mode;
      next_rdata[`SDAC_STAT_NOREF] = reference_missing_flag;
      next_rdata[`SDAC_STAT_PERR] = primary_cal_error;
      next_rdata[`SDAC_STAT_AERR] = aux_cal_error;
    end else if (paddr == `SDAC_PCC_ADDR) begin
      next_rdata[0] = primary_converter_control;
    end else if (paddr == `SDAC_ACC_ADDR) begin
      next_rdata[0] = aux_converter_control;
    end else if (paddr == `SDAC_PDATA_ADDR) begin
      next_rdata[DW-1:0] = data_out[0];
    end else if (paddr == `SDAC_ADATA_ADDR) begin
      next_rdata[DW-1:0] = data_out[1];
    end else if (paddr == `SDAC_POFF_ADDR) begin
      next_rdata[DW-1:0] = offset_coef[0];
    end else if (paddr == `SDAC_PGAIN_ADDR) begin
      next_rdata[DW-1:0] = gain_coef[0];
    end else if (paddr == `SDAC_AOFF_ADDR) begin
      next_rdata[DW-1:0] = offset_coef[1];
    end else if (paddr == `SDAC_AGAIN_ADDR) begin
      next_rdata[DW-1:0] = gain_coef[1];
    end else begin
      next_err = 1'b1;
    end
  end

  // Read data and error are captured in setup and held through access.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h00000000 : next_rdata;
      pslverr <= next_err;
    end else if (!psel) begin
      pslverr <= 1'b0;
    end
  end

endmodule // sdac_control

`default_nettype wire

// >>> verif/sdac_control_sva.sv
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Watches the register bus, the current switches, the input points and the chop phase.
module sdac_control_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic ref_below_threshold,
  input wire logic ref_pos_open,
  input wire logic ref_neg_open,
  input wire logic burnout_source_en,
  input wire logic burnout_sink_en,
  input wire logic [1:0] excitation_out_a,
  input wire logic [1:0] excitation_out_b,
  input wire logic [1:0] primary_input_select,
  input wire logic [1:0] aux_input_select,
  input wire logic chop_swap
);
  // Decoded bus phases and the source counts that a current register write asks for.
  wire logic ref_bad = ref_below_threshold | ref_pos_open | ref_neg_open;
  wire logic setup = psel & !penable;
  wire logic csc_wr = psel & penable & pwrite & (paddr == 12'h000);
  wire logic [1:0] n_a = {1'b0, pwdata[2:1] == 2'h1} + {1'b0, pwdata[4:3] == 2'h1};
  wire logic [1:0] n_b = {1'b0, pwdata[2:1] == 2'h2} + {1'b0, pwdata[4:3] == 2'h2};
  wire logic st_rd = setup & !pwrite & (paddr == 12'h00c);
  // A filter word or mode write restarts the filters and may clear the chop phase at once.
  wire logic rst_wr = psel & penable & pwrite & (paddr == 12'h004 | paddr == 12'h008);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_burnout_pair: assert property (burnout_source_en == burnout_sink_en)
    else $error("burnout currents differ");
  a_burnout_write: assert property (csc_wr |=> burnout_sink_en == $past(pwdata[0]))
    else $error("burnout enable not taken from write");
  a_excite_route: assert property (csc_wr |=> excitation_out_a == $past(n_a)
    && excitation_out_b == $past(n_b))
    else $error("excitation routing wrong");
  a_unmapped_err: assert property (setup && paddr > 12'h02c |=> pslverr)
    else $error("unmapped access without error");
  a_mapped_ok: assert property (setup && paddr <= 12'h02c && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped access flagged as error");
  a_err_clear: assert property (!psel |=> !pslverr)
    else $error("error response outside a transfer");
  a_ready_high: assert property (pready)
    else $error("wait state inserted");
  a_noref_status: assert property (st_rd && $stable(ref_bad)
    |=> prdata[4] == $past(ref_bad))
    else $error("reference flag does not follow detector");
  a_chop_spacing: assert property ($changed(chop_swap)
    |=> (!$changed(chop_swap) || $past(rst_wr)) [*8])
    else $error("chop phase toggled too soon");
  a_select_legal: assert property (primary_input_select != 2'h3
    && aux_input_select != 2'h3)
    else $error("illegal modulator input point");
  // Main scenarios reached.
  c_internal_zero: cover property (primary_input_select == 2'h1);
  c_chop_toggle: cover property ($changed(chop_swap));
  c_unmapped: cover property (pslverr);
endmodule // sdac_control_sva
bind sdac_control sdac_control_sva chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .prdata, .pslverr, .ref_below_threshold, .ref_pos_open, .ref_neg_open,
  .burnout_source_en, .burnout_sink_en, .excitation_out_a, .excitation_out_b,
  .primary_input_select, .aux_input_select, .chop_swap);
`default_nettype wire

// >>> verif/sdac_modulator.sv
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// First-order modulator pair standing in for the analog front end.
module sdac_modulator (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic [1:0] primary_input_select,
  input wire logic [1:0] aux_input_select,
  input wire logic [15:0] pin_level,
  output logic mod_sample_valid,
  output logic mod_bit_primary,
  output logic mod_bit_aux
);
  logic [15:0] acc_p;
  logic [15:0] acc_a;
  logic ph;
  // Internal points give empty or full density, otherwise the level set on the pins.
  function automatic logic [15:0] level(input logic [1:0] sel, input logic [15:0] pins);
    return sel == 2'h1 ? 16'h0000 : (sel == 2'h2 ? 16'hffff : pins);
  endfunction
  // Samples every cycle, or every other one when slow; idle bits flip so stale data shows.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph <= 1'b0;
      acc_p <= 16'h0000;
      acc_a <= 16'h0000;
      mod_sample_valid <= 1'b0;
      mod_bit_primary <= 1'b0;
      mod_bit_aux <= 1'b0;
    end else begin
      ph <= ~ph;
      mod_sample_valid <= !slow || ph;
      if (!slow || ph) begin
        {mod_bit_primary, acc_p} <= {1'b0, acc_p} + level(primary_input_select, pin_level);
        {mod_bit_aux, acc_a} <= {1'b0, acc_a} + level(aux_input_select, pin_level);
      end else begin
        mod_bit_primary <= ~mod_bit_primary;
        mod_bit_aux <= ~mod_bit_aux;
      end
    end
  end
endmodule // sdac_modulator
`default_nettype wire

// >>> verif/sdac_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
////////////////////////////////////////////////////////////////////////////////
// Drives the converter control block over its register bus and checks the results.
module sdac_control_bench;
  typedef struct {logic [32:0] v; logic [31:0] m;} sdac_note;
  localparam logic [23:0] FAC [4] = '{24'h0a1b2c, 24'h5d6e7f, 24'h102030, 24'h405060};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic chk_now = 1'b0, slow = 1'b0, ref_below_threshold = 1'b0;
  logic ref_pos_open = 1'b0, ref_neg_open = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q, d;
  logic [15:0] pin_level = 16'h6000;
  logic pready, pslverr, mod_sample_valid, mod_bit_primary, mod_bit_aux;
  logic burnout_source_en, burnout_sink_en, chop_swap;
  logic [1:0] excitation_out_a, excitation_out_b, primary_input_select, aux_input_select;
  int errors = 0, n_compared = 0, cyc = 0, seed = 32'h8953, t, i;
  sdac_note notes[$];
  sdac_note e;
  sdac_control dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .mod_sample_valid, .mod_bit_primary, .mod_bit_aux,
    .ref_below_threshold, .ref_pos_open, .ref_neg_open, .factory_offset_primary(FAC[0]),
    .factory_gain_primary(FAC[1]), .factory_offset_aux(FAC[2]), .factory_gain_aux(FAC[3]),
    .burnout_source_en, .burnout_sink_en, .excitation_out_a, .excitation_out_b,
    .primary_input_select, .aux_input_select, .chop_swap);
  sdac_modulator mod_u (.pclk, .presetn, .slow, .primary_input_select, .aux_input_select,
    .pin_level, .mod_sample_valid, .mod_bit_primary, .mod_bit_aux);
  // Clock and hang limit.
  initial forever #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      wrap_up;
    end
  end
  // Takes the oldest note whenever a checked read completes.
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && chk_now) begin
      e = notes.pop_front();
      `CHK($sformatf("read %h", paddr), e.v, {pslverr, prdata & e.m})
    end
  end
  // Prints the verdict and ends the run.
  task automatic wrap_up;
    if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One bus transfer; a checked read leaves its expected value as a note.
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd,
    input logic c, input logic [32:0] ev, input logic [31:0] m);
    if (c) notes.push_back('{ev, m});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    chk_now <= c;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    apb(a, 1'b1, wd, 1'b0, 33'h0, 32'h0);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [32:0] ev, input logic [31:0] m);
    apb(a, 1'b0, 32'h0, 1'b1, ev, m);
  endtask
  // Polls the status until all bits of the mask are set, counting cycles.
  task automatic poll(input logic [31:0] m);
    t = cyc;
    do apb(12'h00c, 1'b0, 32'h0, 1'b0, 33'h0, 32'h0); while ((q & m) !== m);
    t = cyc - t;
  endtask
  // Number of excitation sources that a routing field sends to one pin.
  function automatic logic [1:0] cnt(input logic [31:0] v, input logic [1:0] p);
    return {1'b0, v[2:1] == p} + {1'b0, v[4:3] == p};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(12'h004, {25'h0, 8'h45}, 32'hff);
    for (i = 0; i < 4; i++) rd_chk(12'(32'h20 + 4 * i), {9'h0, FAC[i]}, 32'hffffff);
    rd_chk(12'h030, {1'b1, 32'h0}, 32'h0);
    for (i = 0; i < 8; i++) begin
      d = $random(seed);
      wr(12'h000, d);
      @(negedge pclk);
      `CHK("burnout", {2{d[0]}}, {burnout_source_en, burnout_sink_en})
      `CHK("excite", {cnt(d, 2'h1), cnt(d, 2'h2)}, {excitation_out_a, excitation_out_b})
      rd_chk(12'h000, {28'h0, d[4:0]}, 32'h1f);
    end
    for (i = 0; i < 3; i++) begin
      {ref_below_threshold, ref_pos_open, ref_neg_open} <= 3'b100 >> i;
      repeat (2) @(posedge pclk);
      rd_chk(12'h00c, {1'b0, 32'h10}, 32'h10);
      {ref_below_threshold, ref_pos_open, ref_neg_open} <= 3'b000;
      repeat (2) @(posedge pclk);
      rd_chk(12'h00c, 33'h0, 32'h10);
    end
    wr(12'h004, 32'hd);
    wr(12'h024, 32'h0);
    wr(12'h010, 32'h0);
    wr(12'h008, 32'h12);
    poll(32'h80);
    `CHK("settling", 1'b1, t >= 208)
    rd_chk(12'h018, {9'h0, 24'h800000}, 32'hffffff);
    wr(12'h010, 32'h1);
    slow <= 1'b1;
    poll(32'h80);
    rd_chk(12'h018, 33'h0, 32'hffffff);
    ref_below_threshold <= 1'b1;
    poll(32'h80);
    apb(12'h018, 1'b0, 32'h0, 1'b0, 33'h0, 32'h0);
    poll(32'h80);
    rd_chk(12'h018, {9'h0, 24'hffffff}, 32'hffffff);
    ref_below_threshold <= 1'b0;
    slow <= 1'b0;
    wr(12'h008, 32'h0);
    for (i = 4; i < 8; i++) begin
      wr(12'h020, 32'h111111);
      wr(12'h024, 32'h222222);
      wr(12'h008, 32'h10 | i);
      @(negedge pclk);
      `CHK("select", 4'(i < 6 ? i - 3 : 0), {aux_input_select, primary_input_select})
      poll(32'h80);
      `CHK("cal time", 1'b1, t >= 4080)
      rd_chk(i[0] ? 12'h020 : 12'h024, i[0] ? 33'h111111 : 33'h222222, 32'hffffff);
      rd_chk(12'h028, {9'h0, FAC[2]}, 32'hffffff);
      apb(12'h018, 1'b0, 32'h0, 1'b0, 33'h0, 32'h0);
    end
    wr(12'h008, 32'h34);
    repeat (1000) @(posedge pclk);
    ref_pos_open <= 1'b1;
    repeat (4) @(posedge pclk);
    ref_pos_open <= 1'b0;
    poll(32'hc0);
    rd_chk(12'h00c, {1'b0, 32'hc}, 32'hc);
    rd_chk(12'h020, {9'h0, 24'h111111}, 32'hffffff);
    rd_chk(12'h028, {9'h0, FAC[2]}, 32'hffffff);
    wr(12'h00c, 32'hc);
    rd_chk(12'h00c, 33'h0, 32'hc);
    // A second reset in mid-run must reload the factory coefficients and the filter word.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 4; i++) rd_chk(12'(32'h20 + 4 * i), {9'h0, FAC[i]}, 32'hffffff);
    rd_chk(12'h004, {25'h0, 8'h45}, 32'hff);
    wrap_up;
  end
endmodule // sdac_control_bench
`default_nettype wire
